// ### hw/sysctl_defines.svh
`ifndef SYSCTL_DEFINES_SVH
`define SYSCTL_DEFINES_SVH

// register indexes; byte address is four times the index
`define IDX_W 9
`define ADDR_W 11
`define IDX_CH4_DUTY_HIGH 9'h09c
`define IDX_CH4_DUTY_LOW 9'h09d
`define IDX_CH5_DUTY_HIGH 9'h09e
`define IDX_CH5_DUTY_LOW 9'h09f
`define IDX_RAM_FIRST 9'h0a0
`define IDX_RAM_LAST 9'h0ef
`define IDX_PIN_MODE 9'h105
`define IDX_RESET_DISABLE 9'h109
`define IDX_PC_HIGH 9'h10c
`define IDX_BANDGAP_TRIM 9'h10e
`define IDX_OSC_TRIM 9'h10f
`define IDX_BANDGAP_2V 9'h111

`define RAM_DEPTH 80
`define RAM_AW 7

`define RST_DUTY_HIGH 8'h80
`define RST_DUTY_LOW 8'h00
`define RST_SINK 1'b1

`define BIT_SINK 2
`define BIT_PIN_RSVD5 5
`define BIT_POR_FLAG 1
`define BIT_LVR_FLAG 0

`define CODE_BOTH_OFF 8'h37
`define CODE_LVR_OFF 8'h38
`define CODE_POR_OFF 8'h39
`define CODE_PC_HOLD 8'h1c

`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// ### hw/sysctl_pkg.sv
package sysctl_pkg;

  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } duty_t;

  typedef struct packed {
    logic [4:0] bandgap;
    logic [6:0] oscillator;
    logic [7:0] bandgap_2v;
  } trim_t;

  typedef struct packed {
    logic poweron;
    logic lowvolt;
  } reset_off_t;

endpackage

// ### hw/system_control_register_bank.sv
`timescale 1ns/1ps
`include "sysctl_defines.svh"

module system_control_register_bank (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [`ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [`ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [3:0] pc_current_high,
  input wire sysctl_pkg::trim_t cfg_trim,
  output sysctl_pkg::duty_t channel4_duty,
  output sysctl_pkg::duty_t channel5_duty,
  output logic sink_strength_select,
  output sysctl_pkg::reset_off_t reset_off,
  output logic pc_high_hold_flag,
  output logic [4:0] bandgap_trim,
  output logic [6:0] oscillator_trim
);

  function automatic logic [`IDX_W-1:0] index_of(input logic [`ADDR_W-1:0] addr);
    index_of = addr[`ADDR_W-1:2];
  endfunction

  function automatic logic is_ram(input logic [`IDX_W-1:0] idx);
    is_ram = (idx >= `IDX_RAM_FIRST) && (idx <= `IDX_RAM_LAST);
  endfunction

  function automatic logic [`RAM_AW-1:0] ram_slot(input logic [`IDX_W-1:0] idx);
    logic [`IDX_W-1:0] diff;
    diff = idx - `IDX_RAM_FIRST;
    ram_slot = diff[`RAM_AW-1:0];
  endfunction

  function automatic logic is_mapped(input logic [`IDX_W-1:0] idx);
    unique case (idx)
      `IDX_CH4_DUTY_HIGH, `IDX_CH4_DUTY_LOW, `IDX_CH5_DUTY_HIGH, `IDX_CH5_DUTY_LOW,
      `IDX_PIN_MODE, `IDX_RESET_DISABLE, `IDX_PC_HIGH, `IDX_BANDGAP_TRIM,
      `IDX_OSC_TRIM, `IDX_BANDGAP_2V: is_mapped = 1'b1;
      default: is_mapped = is_ram(idx);
    endcase
  endfunction

  logic aw_held;
  logic w_held;
  logic [`IDX_W-1:0] wr_idx;
  logic [7:0] wr_byte;
  logic wr_lane;
  logic do_write;
  logic reg_write;
  logic [`IDX_W-1:0] rd_idx;
  logic [7:0] ram [0:`RAM_DEPTH-1];
  logic pin_rsvd5;
  logic [1:0] pin_low_bits;
  logic [3:0] pc_high_seen;
  logic [7:0] bandgap_2v_trim_copy;
  logic [7:0] next_read_byte;

  assign do_write = aw_held && w_held && !bvalid;
  // a write whose low lane is masked off still answers but changes nothing
  assign reg_write = do_write && wr_lane;
  assign rd_idx = index_of(araddr);

  // write address channel
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      aw_held <= 1'b0;
      awready <= 1'b1;
      wr_idx <= '0;
    end else if (awvalid && awready) begin
      aw_held <= 1'b1;
      awready <= 1'b0;
      wr_idx <= index_of(awaddr);
    end else if (do_write) begin
      aw_held <= 1'b0;
    end else if (bvalid && bready) begin
      awready <= 1'b1;
    end
  end

  // write data channel, taken in any order against the address
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      w_held <= 1'b0;
      wready <= 1'b1;
      wr_byte <= '0;
      wr_lane <= 1'b0;
    end else if (wvalid && wready) begin
      w_held <= 1'b1;
      wready <= 1'b0;
      wr_byte <= wdata[7:0];
      wr_lane <= wstrb[0];
    end else if (do_write) begin
      w_held <= 1'b0;
    end else if (bvalid && bready) begin
      wready <= 1'b1;
    end
  end

  // write response; unmapped indexes answer with slave error
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
    end else if (do_write) begin
      bvalid <= 1'b1;
      bresp <= is_mapped(wr_idx) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (bvalid && bready) begin
      bvalid <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      channel4_duty <= '{high: `RST_DUTY_HIGH, low: `RST_DUTY_LOW};
      channel5_duty <= '{high: `RST_DUTY_HIGH, low: `RST_DUTY_LOW};
    end else if (reg_write) begin
      if (wr_idx == `IDX_CH4_DUTY_HIGH) begin
        channel4_duty.high <= wr_byte;
      end
      if (wr_idx == `IDX_CH4_DUTY_LOW) begin
        channel4_duty.low <= wr_byte;
      end
      if (wr_idx == `IDX_CH5_DUTY_HIGH) begin
        channel5_duty.high <= wr_byte;
      end
      if (wr_idx == `IDX_CH5_DUTY_LOW) begin
        channel5_duty.low <= wr_byte;
      end
    end
  end

  // general RAM, no reset on purpose
  always_ff @(posedge ref_clk) begin
    if (reg_write && is_ram(wr_idx)) begin
      ram[ram_slot(wr_idx)] <= wr_byte;
    end
  end

  // sink strength and the two keep-at-zero bits
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sink_strength_select <= `RST_SINK;
      pin_low_bits <= 2'h0;
    end else if (reg_write && wr_idx == `IDX_PIN_MODE) begin
      sink_strength_select <= wr_byte[`BIT_SINK];
      pin_low_bits <= wr_byte[1:0];
    end
  end

  // reserved bit is never reset nor written, so it reads unknown
  always_ff @(posedge ref_clk) begin
    pin_rsvd5 <= pin_rsvd5;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      reset_off <= '{poweron: 1'b0, lowvolt: 1'b0};
    end else if (reg_write && wr_idx == `IDX_RESET_DISABLE) begin
      unique case (wr_byte)
        `CODE_BOTH_OFF: reset_off <= '{poweron: 1'b1, lowvolt: 1'b1};
        `CODE_LVR_OFF: reset_off <= '{poweron: 1'b0, lowvolt: 1'b1};
        `CODE_POR_OFF: reset_off <= '{poweron: 1'b1, lowvolt: 1'b0};
        default: reset_off <= '{poweron: 1'b0, lowvolt: 1'b0};
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pc_high_hold_flag <= 1'b0;
    end else if (reg_write && wr_idx == `IDX_PC_HIGH) begin
      pc_high_hold_flag <= (wr_byte == `CODE_PC_HOLD);
    end
  end

  // program counter bits 11..8 sampled for read back
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pc_high_seen <= 4'h0;
    end else begin
      pc_high_seen <= pc_current_high;
    end
  end

  // trims load stored configuration; 2 V copy is read only
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      bandgap_trim <= cfg_trim.bandgap;
      oscillator_trim <= cfg_trim.oscillator;
      bandgap_2v_trim_copy <= cfg_trim.bandgap_2v;
    end else if (reg_write) begin
      if (wr_idx == `IDX_BANDGAP_TRIM) begin
        bandgap_trim <= wr_byte[4:0];
      end
      if (wr_idx == `IDX_OSC_TRIM) begin
        oscillator_trim <= wr_byte[6:0];
      end
    end
  end

  // read value mux
  always_comb begin
    next_read_byte = 8'h00;
    unique case (rd_idx)
      `IDX_CH4_DUTY_HIGH: next_read_byte = channel4_duty.high;
      `IDX_CH4_DUTY_LOW: next_read_byte = channel4_duty.low;
      `IDX_CH5_DUTY_HIGH: next_read_byte = channel5_duty.high;
      `IDX_CH5_DUTY_LOW: next_read_byte = channel5_duty.low;
      `IDX_PIN_MODE: next_read_byte = {2'h0, pin_rsvd5, 2'h0, sink_strength_select,
        pin_low_bits};
      `IDX_RESET_DISABLE: next_read_byte = {6'h00, reset_off.poweron, reset_off.lowvolt};
      `IDX_PC_HIGH: next_read_byte = {4'h0, pc_high_seen};
      `IDX_BANDGAP_TRIM: next_read_byte = {3'h0, bandgap_trim};
      `IDX_OSC_TRIM: next_read_byte = {1'h0, oscillator_trim};
      `IDX_BANDGAP_2V: next_read_byte = bandgap_2v_trim_copy;
      default: begin
        if (is_ram(rd_idx)) begin
          next_read_byte = ram[ram_slot(rd_idx)];
        end
      end
    endcase
  end

  // read channel
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= `RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= {24'h000000, next_read_byte};
      rresp <= is_mapped(rd_idx) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  a_duty_reset_val: assert property (
    $fell(reset) |-> channel4_duty == {`RST_DUTY_HIGH, `RST_DUTY_LOW}
      && channel5_duty == {`RST_DUTY_HIGH, `RST_DUTY_LOW})
    else $error("duty reset value wrong");

  a_duty_write_lands: assert property (
    reg_write && wr_idx == `IDX_CH5_DUTY_HIGH |=> channel5_duty.high == $past(wr_byte))
    else $error("duty high byte not written");

  a_ram_read_ok: assert property (
    arvalid && arready && is_ram(rd_idx) |=> rvalid && rresp == `RESP_OKAY)
    else $error("ram read not answered okay");

  a_sink_reset_high: assert property (
    $fell(reset) |-> sink_strength_select)
    else $error("sink strength not high after reset");

  a_sink_follows_write: assert property (
    reg_write && wr_idx == `IDX_PIN_MODE
      |=> {7'h00, sink_strength_select} == (($past(wr_byte) >> `BIT_SINK) & 8'h01))
    else $error("sink strength not written");

  a_both_resets_off: assert property (
    reg_write && wr_idx == `IDX_RESET_DISABLE && wr_byte == `CODE_BOTH_OFF
      |=> reset_off.poweron && reset_off.lowvolt)
    else $error("both resets not forced off");

  a_lowvolt_only_off: assert property (
    reg_write && wr_idx == `IDX_RESET_DISABLE && wr_byte == `CODE_LVR_OFF
      |=> !reset_off.poweron && reset_off.lowvolt)
    else $error("low-voltage only code wrong");

  a_poweron_only_off: assert property (
    reg_write && wr_idx == `IDX_RESET_DISABLE && wr_byte == `CODE_POR_OFF
      |=> reset_off.poweron && !reset_off.lowvolt)
    else $error("power-on only code wrong");

  a_other_code_on: assert property (
    reg_write && wr_idx == `IDX_RESET_DISABLE && wr_byte != `CODE_BOTH_OFF
      && wr_byte != `CODE_LVR_OFF && wr_byte != `CODE_POR_OFF
      |=> reset_off == 2'b00)
    else $error("other code did not enable resets");

  a_flags_read_back: assert property (
    arvalid && arready && rd_idx == `IDX_RESET_DISABLE
      |=> rdata[1:0] == $past(reset_off))
    else $error("reset flags read back wrong");

  a_hold_flag_write: assert property (
    reg_write && wr_idx == `IDX_PC_HIGH
      |=> pc_high_hold_flag == ($past(wr_byte) == `CODE_PC_HOLD))
    else $error("hold flag not set or cleared by write");

  a_hold_flag_reset: assert property (
    $fell(reset) |-> !pc_high_hold_flag)
    else $error("hold flag not cleared by reset");

  a_pc_high_read: assert property (
    arvalid && arready && rd_idx == `IDX_PC_HIGH
      |=> rdata == {28'h0000000, $past(pc_high_seen)})
    else $error("pc high read wrong");

  a_bandgap_2v_ro: assert property (
    reg_write && wr_idx == `IDX_BANDGAP_2V |=> $stable(bandgap_2v_trim_copy))
    else $error("2 V trim copy changed by write");

  a_write_resp_up: assert property (
    do_write |=> bvalid && !awready && !wready)
    else $error("write response not raised");

  a_write_ready_back: assert property (
    bvalid && bready |=> !bvalid && awready && wready)
    else $error("write channels not reopened");

  a_read_answer: assert property (
    arvalid && arready |=> rvalid && !arready)
    else $error("read not answered next cycle");

  a_read_reopen: assert property (
    rvalid && rready |=> !rvalid && arready)
    else $error("read channel not reopened");

  a_hold_other_clear: assert property (
    reg_write && wr_idx == `IDX_PC_HIGH && wr_byte != `CODE_PC_HOLD
      |=> !pc_high_hold_flag)
    else $error("hold flag not cleared by other value");

  a_masked_write_kept: assert property (
    do_write && !wr_lane |=> $stable(channel4_duty) && $stable(channel5_duty))
    else $error("masked write changed a duty byte");

  a_trim_reset_load: assert property (
    $fell(reset)
      |-> {bandgap_trim, oscillator_trim, bandgap_2v_trim_copy} == $past(cfg_trim))
    else $error("trims not loaded from stored configuration");

  a_osc_trim_write: assert property (
    reg_write && wr_idx == `IDX_OSC_TRIM
      |=> oscillator_trim == 7'($past(wr_byte)))
    else $error("oscillator trim not written");

  a_unmapped_slverr: assert property (
    do_write && !is_mapped(wr_idx) |=> bresp == `RESP_SLVERR)
    else $error("unmapped write not refused");

endmodule

// ### tb/system_control_register_bank_tb_top.sv
`timescale 1ns/1ps
`include "sysctl_defines.svh"
module system_control_register_bank_tb_top;
  logic ref_clk, reset, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, sink, hold;
  logic [10:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb, pc;
  logic [1:0] bresp, rresp, rsp;
  logic [4:0] bg;
  logic [6:0] osc;
  logic [7:0] v, p;
  logic [7:0] ram_exp [0:79];
  sysctl_pkg::trim_t cfg;
  sysctl_pkg::duty_t d4, d5;
  sysctl_pkg::reset_off_t roff;
  int bad_count = 0;
  int num_checks = 0;
  int cycles = 0;

  system_control_register_bank u_dut (.ref_clk(ref_clk), .reset(reset),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .pc_current_high(pc), .cfg_trim(cfg),
    .channel4_duty(d4), .channel5_duty(d5), .sink_strength_select(sink), .reset_off(roff),
    .pc_high_hold_flag(hold), .bandgap_trim(bg), .oscillator_trim(osc));

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task close_out;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // whole run is under a thousand cycles; the ceiling leaves wide margin
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 8000) begin
      bad_count++;
      close_out();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // upper data bits are random so that only the low byte may matter
  task automatic wr(input logic [8:0] i, input logic [7:0] d, input logic [3:0] s = 4'h1);
    @(posedge ref_clk);
    awaddr <= {i, 2'b00};
    wdata <= {24'($urandom), d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    rsp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd_reg(input logic [8:0] i);
    @(posedge ref_clk);
    araddr <= {i, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask

  task automatic rchk(input string nm, input logic [8:0] i, input logic [7:0] e,
                      input logic [1:0] er = `RESP_OKAY);
    rd_reg(i);
    chk(nm, {24'h0, e}, rd);
    chk({nm, " resp"}, {30'h0, er}, {30'h0, rsp});
  endtask

  function automatic logic [1:0] off_flags(input logic [7:0] c);
    case (c)
      `CODE_BOTH_OFF: return 2'b11;
      `CODE_LVR_OFF: return 2'b01;
      `CODE_POR_OFF: return 2'b10;
      default: return 2'b00;
    endcase
  endfunction

  task automatic reset_pulse;
    reset <= 1'b1;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic reset_state_chk;
    chk("ch4 duty", 32'h8000, d4);
    chk("ch5 duty", 32'h8000, d5);
    chk("sink", 32'h1, sink);
    chk("reset off", 32'h0, roff);
    chk("hold", 32'h0, hold);
    chk("trims", {cfg.bandgap, cfg.oscillator}, {bg, osc});
  endtask

  initial begin
    reset = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 11'h000;
    araddr = 11'h000;
    wdata = 32'h0;
    wstrb = 4'h0;
    pc = 4'h0;
    void'($urandom(32036));
    cfg = 20'($urandom);
    reset_pulse();
    reset_state_chk();
    rchk("2v trim", `IDX_BANDGAP_2V, cfg.bandgap_2v);
    rchk("pc high", `IDX_PC_HIGH, 8'h00);
    rchk("reset dis", `IDX_RESET_DISABLE, 8'h00);
    rchk("bg trim", `IDX_BANDGAP_TRIM, {3'h0, cfg.bandgap});
    rd_reg(`IDX_PIN_MODE);
    chk("pin mode", 32'h4, rd & 32'h7);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      v = 8'($urandom);
      wr(9'(`IDX_CH4_DUTY_HIGH + i), v);
      wr(9'(`IDX_CH4_DUTY_HIGH + i), ~v, 4'he);
      rchk("duty", 9'(`IDX_CH4_DUTY_HIGH + i), v);
      chk("duty port", {24'h0, v}, ({d4, d5} >> (8 * (3 - i))) & 32'hff);
    end
    $display("test duty done");
    for (int i = 0; i < 80; i++) begin
      ram_exp[i] = 8'($urandom);
      wr(9'(`IDX_RAM_FIRST + i), ram_exp[i]);
    end
    for (int i = 0; i < 80; i++) rchk("ram", 9'(`IDX_RAM_FIRST + i), ram_exp[i]);
    $display("test ram done");
    for (int i = 0; i < 9; i++) begin
      v = (i < 3) ? 8'(`CODE_BOTH_OFF + i) : 8'($urandom);
      wr(`IDX_RESET_DISABLE, v);
      chk("off port", {30'h0, off_flags(v)}, roff);
      rchk("off flags", `IDX_RESET_DISABLE, {6'h0, off_flags(v)});
    end
    $display("test reset disable done");
    for (int i = 0; i < 5; i++) begin
      v = (i % 2 == 0) ? `CODE_PC_HOLD : 8'($urandom);
      wr(`IDX_PC_HIGH, v);
      chk("hold", {31'h0, v == `CODE_PC_HOLD}, hold);
      p = 8'($urandom);
      pc <= p[3:0];
      rchk("pc high", `IDX_PC_HIGH, {4'h0, p[3:0]});
    end
    $display("test pc high done");
    wr(9'h1ff, 8'($urandom));
    chk("unmapped wr", 32'h2, rsp);
    rchk("unmapped rd", 9'h0f0, 8'h00, `RESP_SLVERR);
    wr(`IDX_BANDGAP_2V, ~cfg.bandgap_2v);
    chk("ro wr", 32'h0, rsp);
    rchk("2v kept", `IDX_BANDGAP_2V, cfg.bandgap_2v);
    wr(`IDX_BANDGAP_TRIM, 8'hff);
    wr(`IDX_OSC_TRIM, 8'hff);
    chk("trim ports", {5'h1f, 7'h7f}, {bg, osc});
    rchk("osc trim", `IDX_OSC_TRIM, 8'h7f);
    wr(`IDX_PIN_MODE, 8'h00);
    chk("sink low", 32'h0, sink);
    rd_reg(`IDX_PIN_MODE);
    chk("pin mode", 32'h0, rd & 32'h7);
    $display("test refusals done");
    wr(`IDX_RESET_DISABLE, `CODE_BOTH_OFF);
    wr(`IDX_PC_HIGH, `CODE_PC_HOLD);
    @(posedge ref_clk);
    cfg <= 20'($urandom);
    reset_pulse();
    reset_state_chk();
    $display("test second reset done");
    close_out();
  end
endmodule
